// ### rtl/bgdp_consts.svh
// Offsets-free constants: timing figures and derived cycle counts for the gate supervisor.
`ifndef BGDP_CONSTS_SVH
`define BGDP_CONSTS_SVH
`define BGDP_CLK_MHZ          20
`define BGDP_BLANK_NS         2000
`define BGDP_BLANK_CYC        ((`BGDP_BLANK_NS * `BGDP_CLK_MHZ + 999) / 1000)
`define BGDP_HDEG_NS          20000
`define BGDP_HDEG_CYC         ((`BGDP_HDEG_NS * `BGDP_CLK_MHZ + 999) / 1000)
`define BGDP_VDS_DEG_NS       4500
`define BGDP_VDS_DEG_CYC      ((`BGDP_VDS_DEG_NS * `BGDP_CLK_MHZ + 999) / 1000)
`define BGDP_SEN_DEG_NS       4000
`define BGDP_SEN_DEG_CYC      ((`BGDP_SEN_DEG_NS * `BGDP_CLK_MHZ + 999) / 1000)
`define BGDP_RETRY_US         4000
`define BGDP_RETRY_CYC        (`BGDP_RETRY_US * `BGDP_CLK_MHZ)
`define BGDP_SLEEP_US         1000
`define BGDP_SLEEP_CYC        (`BGDP_SLEEP_US * `BGDP_CLK_MHZ)
`define BGDP_WAKE_US          1000
`define BGDP_WAKE_CYC         (`BGDP_WAKE_US * `BGDP_CLK_MHZ)
`define BGDP_RST_MIN_NS       15000
`define BGDP_RST_MIN_CYC      ((`BGDP_RST_MIN_NS * `BGDP_CLK_MHZ + 999) / 1000)
`define BGDP_RST_MAX_NS       40000
`define BGDP_RST_MAX_CYC      ((`BGDP_RST_MAX_NS * `BGDP_CLK_MHZ) / 1000)
`define BGDP_TDRIVE_NS        4000
`define BGDP_TDRIVE_CYC       ((`BGDP_TDRIVE_NS * `BGDP_CLK_MHZ) / 1000)
`define BGDP_SEL_LEVELS       7
`define BGDP_VDS_OFF_CODE     3'h6
`endif

// ### rtl/bgdp_pkg.sv
// Types shared by the gate supervisor: modes, fault inputs and state.
package bgdp_pkg;
    typedef enum logic [1:0] {BGDP_SLEEP, BGDP_WAKE, BGDP_RUN, BGDP_DOWN} bgdp_mode_e;
    typedef struct packed {
        logic supply_low;
        logic pump_low;
        logic ds_trip;
        logic sense_ocp;
        logic gate_stuck;
        logic hot;
    } bgdp_cmp_s;
    typedef struct packed {
        logic [2:0] gate_current;
        logic [2:0] ds_threshold;
    } bgdp_strap_s;
    typedef struct packed {
        bgdp_mode_e  mode;
        logic [19:0] mode_cnt;
        logic [19:0] en_low_cnt;
        logic        en_d;
        logic        pwm_d;
        logic        hs_cut;
        logic [6:0]  blank_cnt;
        logic [2:0]  hall;
        logic [8:0]  hall_cnt0;
        logic [8:0]  hall_cnt1;
        logic [8:0]  hall_cnt2;
        logic        speed;
        logic [6:0]  ds_cnt;
        logic [6:0]  sen_cnt;
        logic        retry;
        logic [16:0] retry_cnt;
        logic        gate_latched;
        logic [6:0]  drive_cnt;
        bgdp_strap_s strap;
    } bgdp_state_s;
endpackage

// ### rtl/bgdp_supervisor.sv
// Gate-driver supervision: current limit, Hall deglitch, faults, sleep and strap latching.
`timescale 1ns/100ps
`default_nettype none
`include "bgdp_consts.svh"
module bgdp_supervisor #(
    parameter int RETRY_CYC = `BGDP_RETRY_CYC,
    parameter int SLEEP_CYC = `BGDP_SLEEP_CYC,
    parameter int WAKE_CYC  = `BGDP_WAKE_CYC
) (
    // Clock, reset and enable.
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire logic                  clk_en,
    // Controller pins.
    input  wire logic                  enable,
    input  wire logic                  pwm,
    // Analog comparator results, Hall inputs and strap settings.
    input  wire logic                  sense_limit,
    input  wire logic [2:0]            hall_in,
    input  wire bgdp_pkg::bgdp_cmp_s   cmp,
    input  wire bgdp_pkg::bgdp_strap_s strap_in,
    // Driver commands.
    output logic                       high_gate_out,
    output logic                       low_gate_out,
    output logic                       drivers_hiz,
    output logic                       gate_pulldown,
    output logic                       pump_on,
    output logic                       regulators_on,
    output logic [2:0]                 gate_current_select,
    output logic [2:0]                 drain_source_threshold_select,
    output logic                       drive_strong,
    // Open-drain status pins, enable low means pulling low.
    output logic                       fault_out_low_o,
    output logic                       fault_out_low_oe_n,
    output logic                       hall_speed_out_o,
    output logic                       hall_speed_out_oe_n
);
    import bgdp_pkg::*;

    bgdp_state_s st;
    bgdp_state_s next_st;

    logic pwm_rise;
    logic en_fall;
    logic en_rise;
    logic rst_pulse;
    logic ds_enabled;
    logic auto_block;
    logic run_ok;
    logic hs_on;
    logic fault_any;

    // Edge terms and fault summary shared by the next-state logic and the outputs.
    always_comb begin
        pwm_rise   = pwm & ~st.pwm_d;
        en_fall    = ~enable & st.en_d;
        en_rise    = enable & ~st.en_d;
        rst_pulse  = en_rise && st.mode == BGDP_RUN
                     && st.en_low_cnt >= 20'(`BGDP_RST_MIN_CYC);
        ds_enabled = st.strap.ds_threshold != `BGDP_VDS_OFF_CODE;
        auto_block = cmp.supply_low | cmp.pump_low | cmp.hot;
        run_ok     = st.mode == BGDP_RUN && enable && !auto_block && !st.retry
                     && !st.gate_latched;
        hs_on      = run_ok && pwm && !st.hs_cut;
        fault_any  = auto_block | st.retry | st.gate_latched;
    end

    // One pass over the whole state; the struct is registered below.
    always_comb begin
        next_st       = st;
        next_st.en_d  = enable;
        next_st.pwm_d = pwm;
        // Mode sequencing through wake, run and the delayed sleep entry.
        unique case (st.mode)
            BGDP_SLEEP: begin
                if (enable && !cmp.supply_low) begin
                    next_st.mode     = BGDP_WAKE;
                    next_st.mode_cnt = '0;
                end
            end
            BGDP_WAKE: begin
                next_st.strap    = strap_in;
                next_st.mode_cnt = st.mode_cnt + 20'h00001;
                if (!enable) begin
                    next_st.mode = BGDP_SLEEP;
                end else if (st.mode_cnt >= 20'(WAKE_CYC - 1)) begin
                    next_st.mode = BGDP_RUN;
                end
            end
            BGDP_RUN: begin
                if (!enable && st.en_low_cnt >= 20'(`BGDP_RST_MAX_CYC)) begin
                    next_st.mode     = BGDP_DOWN;
                    next_st.mode_cnt = 20'(`BGDP_RST_MAX_CYC);
                end
            end
            BGDP_DOWN: begin
                next_st.mode_cnt = st.mode_cnt + 20'h00001;
                if (enable) begin
                    next_st.mode = BGDP_RUN;
                end else if (st.mode_cnt >= 20'(SLEEP_CYC - 1)) begin
                    next_st.mode = BGDP_SLEEP;
                end
            end
        endcase
        // Width of the enable low phase, used for reset pulse and shutdown.
        if (enable || en_fall) begin
            next_st.en_low_cnt = '0;
        end else if (st.en_low_cnt != 20'hfffff) begin
            next_st.en_low_cnt = st.en_low_cnt + 20'h00001;
        end
        // A short valid pulse clears the latched gate fault and nothing else.
        if (rst_pulse) begin
            next_st.gate_latched = 1'b0;
        end
        // Blanking after PWM activation, then cycle-by-cycle limit.
        if (pwm_rise) begin
            next_st.hs_cut    = 1'b0;
            next_st.blank_cnt = 7'(`BGDP_BLANK_CYC);
        end else begin
            if (st.blank_cnt != 7'h00) begin
                next_st.blank_cnt = st.blank_cnt - 7'h01;
            end else if (sense_limit && pwm) begin
                next_st.hs_cut = 1'b1;
            end
        end
        // Per-input Hall deglitch: accept an edge then lock the input out.
        if (st.hall_cnt0 != 9'h000) begin
            next_st.hall_cnt0 = st.hall_cnt0 - 9'h001;
        end else if (hall_in[0] != st.hall[0]) begin
            next_st.hall[0]   = hall_in[0];
            next_st.hall_cnt0 = 9'(`BGDP_HDEG_CYC);
        end
        if (st.hall_cnt1 != 9'h000) begin
            next_st.hall_cnt1 = st.hall_cnt1 - 9'h001;
        end else if (hall_in[1] != st.hall[1]) begin
            next_st.hall[1]   = hall_in[1];
            next_st.hall_cnt1 = 9'(`BGDP_HDEG_CYC);
        end
        if (st.hall_cnt2 != 9'h000) begin
            next_st.hall_cnt2 = st.hall_cnt2 - 9'h001;
        end else if (hall_in[2] != st.hall[2]) begin
            next_st.hall[2]   = hall_in[2];
            next_st.hall_cnt2 = 9'(`BGDP_HDEG_CYC);
        end
        // Speed feedback is the parity of the filtered Hall levels.
        next_st.speed = ^next_st.hall;
        // Overcurrent deglitch counters only run while switching is allowed.
        if (cmp.ds_trip && ds_enabled && run_ok) begin
            next_st.ds_cnt = st.ds_cnt + 7'h01;
        end else begin
            next_st.ds_cnt = '0;
        end
        if (cmp.sense_ocp && run_ok) begin
            next_st.sen_cnt = st.sen_cnt + 7'h01;
        end else begin
            next_st.sen_cnt = '0;
        end
        // Timed retry after either overcurrent event.
        if (st.retry) begin
            next_st.retry_cnt = st.retry_cnt + 17'h00001;
            if (st.retry_cnt >= 17'(RETRY_CYC - 1)) begin
                next_st.retry = 1'b0;
            end
        end else if (st.ds_cnt >= 7'(`BGDP_VDS_DEG_CYC)
                     || st.sen_cnt >= 7'(`BGDP_SEN_DEG_CYC)) begin
            next_st.retry     = 1'b1;
            next_st.retry_cnt = '0;
        end
        // Drive period after each gate command; a new PWM edge restarts it.
        if (pwm_rise || (pwm != st.pwm_d)) begin
            next_st.drive_cnt = 7'(`BGDP_TDRIVE_CYC);
        end else if (st.drive_cnt != 7'h00) begin
            next_st.drive_cnt = st.drive_cnt - 7'h01;
            if (st.drive_cnt == 7'h01 && cmp.gate_stuck && run_ok) begin
                next_st.gate_latched = 1'b1;
            end
        end
        if (st.mode == BGDP_SLEEP) begin
            next_st.gate_latched = 1'b0;
            next_st.retry        = 1'b0;
        end
    end

    // State register; clock enable freezes everything.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // Driver and status outputs decoded from the registered state and the live pin and comparator inputs.
    always_comb begin
        high_gate_out       = hs_on;
        low_gate_out        = run_ok && (!pwm || st.hs_cut);
        drivers_hiz         = !run_ok;
        gate_pulldown       = st.mode == BGDP_SLEEP || cmp.supply_low;
        pump_on             = st.mode != BGDP_SLEEP && !cmp.supply_low && !cmp.hot;
        regulators_on       = st.mode != BGDP_SLEEP;
        gate_current_select = st.strap.gate_current;
        drain_source_threshold_select = st.strap.ds_threshold;
        drive_strong        = st.drive_cnt != 7'h00;
        fault_out_low_o     = 1'b0;
        fault_out_low_oe_n  = !(fault_any || st.mode == BGDP_WAKE
                                || st.mode == BGDP_DOWN);
        hall_speed_out_o    = 1'b0;
        hall_speed_out_oe_n = st.speed;
    end

    // Properties guarding the main behaviour.
    property p_limit_cut;
        @(posedge clk_sys) disable iff (!resetn)
        clk_en && st.hs_cut && !pwm_rise |=> st.hs_cut && !high_gate_out;
    endproperty
    a_limit_cut: assert property (p_limit_cut) else $error("high side on while limited");
    property p_sync_rect;
        @(posedge clk_sys) disable iff (!resetn)
        run_ok && st.hs_cut |-> low_gate_out;
    endproperty
    a_sync_rect: assert property (p_sync_rect) else $error("low side off during limit");
    property p_blank;
        @(posedge clk_sys) disable iff (!resetn)
        clk_en && pwm_rise |=> !st.hs_cut && st.blank_cnt == 7'(`BGDP_BLANK_CYC);
    endproperty
    a_blank: assert property (p_blank) else $error("limit set inside blanking");
    property p_blank_hold;
        @(posedge clk_sys) disable iff (!resetn)
        clk_en && st.blank_cnt != 7'h00 && !st.hs_cut |=> !st.hs_cut;
    endproperty
    a_blank_hold: assert property (p_blank_hold) else $error("limit taken while blanked");
    property p_hall_hold;
        @(posedge clk_sys) disable iff (!resetn)
        clk_en && st.hall_cnt0 != 9'h000 |=> $stable(st.hall[0]);
    endproperty
    a_hall_hold: assert property (p_hall_hold) else $error("hall edge inside deglitch");
    property p_auto_fault;
        @(posedge clk_sys) disable iff (!resetn)
        auto_block |-> drivers_hiz && !fault_out_low_oe_n;
    endproperty
    a_auto_fault: assert property (p_auto_fault) else $error("auto fault not reported");
    property p_retry_hiz;
        @(posedge clk_sys) disable iff (!resetn)
        st.retry |-> !high_gate_out && !low_gate_out && !fault_out_low_oe_n;
    endproperty
    a_retry_hiz: assert property (p_retry_hiz) else $error("drivers active during retry");
    property p_latch_hold;
        @(posedge clk_sys) disable iff (!resetn)
        clk_en && st.gate_latched && !rst_pulse && st.mode != BGDP_SLEEP |=> st.gate_latched;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched fault lost");
    property p_pulldown;
        @(posedge clk_sys) disable iff (!resetn)
        st.mode == BGDP_SLEEP |-> gate_pulldown && !pump_on && !regulators_on;
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("sleep outputs wrong");
    property p_strap_frozen;
        @(posedge clk_sys) disable iff (!resetn)
        st.mode == BGDP_RUN && clk_en |=> $stable(st.strap);
    endproperty
    a_strap_frozen: assert property (p_strap_frozen) else $error("strap changed in run");
    // Speed, fault, timing and mode properties; each one guards a single rule of the list.
    property p_speed_parity;
        @(posedge clk_sys) disable iff (!resetn)
        1'b1 |-> (hall_speed_out_oe_n == (^st.hall)) && !hall_speed_out_o;
    endproperty
    a_speed_parity: assert property (p_speed_parity) else $error("speed output wrong");
    property p_pump_fault;
        @(posedge clk_sys) disable iff (!resetn)
        cmp.pump_low |-> drivers_hiz && !fault_out_low_oe_n
                         && (st.mode == BGDP_SLEEP || regulators_on);
    endproperty
    a_pump_fault: assert property (p_pump_fault) else $error("pump fault not handled");
    property p_ds_off;
        @(posedge clk_sys) disable iff (!resetn)
        clk_en && !ds_enabled |=> st.ds_cnt == 7'h00;
    endproperty
    a_ds_off: assert property (p_ds_off) else $error("disabled trip still counted");
    property p_retry_time;
        @(posedge clk_sys) disable iff (!resetn)
        clk_en && st.retry && st.mode != BGDP_SLEEP
        && st.retry_cnt < 17'(RETRY_CYC - 1) |=> st.retry;
    endproperty
    a_retry_time: assert property (p_retry_time) else $error("retry ended early");
    property p_gate_fault;
        @(posedge clk_sys) disable iff (!resetn)
        clk_en && st.drive_cnt == 7'h01 && pwm == st.pwm_d && cmp.gate_stuck && run_ok
        |=> st.gate_latched && !fault_out_low_oe_n;
    endproperty
    a_gate_fault: assert property (p_gate_fault) else $error("gate fault missed");
    property p_hot;
        @(posedge clk_sys) disable iff (!resetn)
        cmp.hot |-> !pump_on && drivers_hiz && !fault_out_low_oe_n;
    endproperty
    a_hot: assert property (p_hot) else $error("thermal fault not handled");
    property p_shutdown;
        @(posedge clk_sys) disable iff (!resetn)
        clk_en && st.mode == BGDP_RUN && !enable
        && st.en_low_cnt >= 20'(`BGDP_RST_MAX_CYC) |=> st.mode == BGDP_DOWN;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("long enable low ignored");
    property p_sleep_entry;
        @(posedge clk_sys) disable iff (!resetn)
        clk_en && st.mode == BGDP_DOWN && !enable
        && st.mode_cnt >= 20'(SLEEP_CYC - 1) |=> st.mode == BGDP_SLEEP;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry late");
    property p_wake_time;
        @(posedge clk_sys) disable iff (!resetn)
        clk_en && st.mode == BGDP_WAKE && enable
        && st.mode_cnt >= 20'(WAKE_CYC - 1) |=> st.mode == BGDP_RUN;
    endproperty
    a_wake_time: assert property (p_wake_time) else $error("fault held past wake");
    property p_run_regs;
        @(posedge clk_sys) disable iff (!resetn)
        st.mode == BGDP_RUN |-> regulators_on && (pump_on || cmp.supply_low || cmp.hot);
    endproperty
    a_run_regs: assert property (p_run_regs) else $error("regulators off in run");
    property p_drive_restart;
        @(posedge clk_sys) disable iff (!resetn)
        clk_en && pwm != st.pwm_d |=> st.drive_cnt == 7'(`BGDP_TDRIVE_CYC);
    endproperty
    a_drive_restart: assert property (p_drive_restart) else $error("drive period not restarted");
    c_limit: cover property (@(posedge clk_sys) disable iff (!resetn) st.hs_cut && pwm);
    c_retry: cover property (@(posedge clk_sys) disable iff (!resetn) st.retry);
    c_reset_pulse: cover property (@(posedge clk_sys) disable iff (!resetn) rst_pulse);
    c_sleep: cover property (@(posedge clk_sys) disable iff (!resetn)
        st.mode == BGDP_DOWN ##1 st.mode == BGDP_SLEEP);
endmodule
`default_nettype wire

// ### bench/bgdp_ctrl_model.sv
// Controller model: drives the enable and PWM pins the way an external microcontroller would.
`timescale 1ns/100ps
`default_nettype none
module bgdp_ctrl_model (
    // Clock.
    input  wire logic clk_sys,
    // Controller pins.
    output logic      enable,
    output logic      pwm
);
    // Both pins start low so the supervisor sits asleep until told otherwise.
    initial begin
        enable = 1'b0;
        pwm    = 1'b0;
    end
    // Pins change just after an edge, like a firmware-driven port.
    task automatic drive_enable(input logic v);
        enable = v;
        @(posedge clk_sys);
        #2;
    endtask
    // A low gap then a rising edge, so every call opens a fresh PWM cycle.
    task automatic pwm_edge();
        pwm = 1'b0;
        repeat (2) @(posedge clk_sys);
        #2 pwm = 1'b1;
    endtask
    // Low phase of 400 cycles sits well inside the reset window, so no shutdown begins.
    task automatic reset_pulse();
        enable = 1'b0;
        repeat (400) @(posedge clk_sys);
        #2 enable = 1'b1;
    endtask
endmodule
`default_nettype wire

// ### bench/bgdp_supervisor_tb.sv
// Self-checking bench for the gate supervisor with expected values given in each check.
`timescale 1ns/100ps
`default_nettype none
module bgdp_supervisor_tb;
    import bgdp_pkg::*;
    localparam int WAKE  = 20;
    localparam int RETRY = 50;
    logic        clk_sys, resetn, clk_en, enable, pwm, sense_limit;
    logic        high_gate_out, low_gate_out, drivers_hiz, gate_pulldown, pump_on;
    logic        regulators_on, drive_strong, f_o, f_oe_n, s_o, s_oe_n;
    logic [2:0]  hall_in, gcs, dss;
    bgdp_cmp_s   cmp;
    bgdp_strap_s strap_in, exp_strap;
    int          bad_count, checked, cycles, hall_edges, seed, dly;
    wire         fault_line = f_oe_n ? 1'b1 : f_o;
    wire         speed_line = s_oe_n ? 1'b1 : s_o;
    bgdp_supervisor #(.RETRY_CYC(RETRY), .SLEEP_CYC(20), .WAKE_CYC(WAKE)) u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .enable(enable), .pwm(pwm),
        .sense_limit(sense_limit), .hall_in(hall_in), .cmp(cmp), .strap_in(strap_in),
        .high_gate_out(high_gate_out), .low_gate_out(low_gate_out),
        .drivers_hiz(drivers_hiz), .gate_pulldown(gate_pulldown), .pump_on(pump_on),
        .regulators_on(regulators_on), .gate_current_select(gcs),
        .drain_source_threshold_select(dss), .drive_strong(drive_strong),
        .fault_out_low_o(f_o), .fault_out_low_oe_n(f_oe_n),
        .hall_speed_out_o(s_o), .hall_speed_out_oe_n(s_oe_n));
    bgdp_ctrl_model u_ctrl (.clk_sys(clk_sys), .enable(enable), .pwm(pwm));
    // Free-running 20 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // A hang would stall the sequence forever, so a cycle ceiling cuts it short.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (bad_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string name, input logic [2:0] exp, input logic [2:0] got);
        checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    // Main sequence; each step checks the outputs against the reference values.
    initial begin
        resetn = 1'b0;
        clk_en = 1'b1;
        sense_limit = 1'b0;
        hall_in = 3'h0;
        cmp = '0;
        strap_in = '0;
        seed = $urandom(66);
        tick(20);
        resetn = 1'b1;
        chk("fault_idle", 1, fault_line);
        chk("pulldown_sleep", 1, gate_pulldown);
        chk("regs_sleep", 0, regulators_on);
        exp_strap = '{3'($urandom_range(6, 0)), 3'($urandom_range(5, 0))};
        strap_in = exp_strap;
        u_ctrl.drive_enable(1'b1);
        tick(5);
        chk("fault_wake", 0, fault_line);
        tick(WAKE + 5);
        chk("fault_run", 1, fault_line);
        chk("regs_run", 1, regulators_on);
        chk("gate_sel", exp_strap.gate_current, gcs);
        chk("ds_sel", exp_strap.ds_threshold, dss);
        strap_in = '{3'h6 - exp_strap.gate_current, 3'h6 - exp_strap.ds_threshold};
        tick(3);
        chk("gate_sel_frozen", exp_strap.gate_current, gcs);
        // Limit pulse inside the blanking time, then a real one after it.
        u_ctrl.pwm_edge();
        tick(2);
        chk("hs_on", 1, high_gate_out);
        chk("drive_on", 1, drive_strong);
        sense_limit = 1'b1;
        tick(3);
        chk("hs_blank", 1, high_gate_out);
        sense_limit = 1'b0;
        dly = $urandom_range(55, 40);
        tick(dly);
        sense_limit = 1'b1;
        tick(2);
        chk("hs_cut", 0, high_gate_out);
        chk("ls_on", 1, low_gate_out);
        sense_limit = 1'b0;
        tick(20);
        chk("hs_still_cut", 0, high_gate_out);
        u_ctrl.pwm_edge();
        tick(2);
        chk("hs_restored", 1, high_gate_out);
        // Hall sensors are fed only now that the driver is awake; a glitch is then ignored.
        hall_in[0] = 1'b1;
        hall_edges++;
        tick(3);
        chk("speed_a", 3'(hall_edges % 2), speed_line);
        tick(50);
        hall_in[1] = 1'b1;
        hall_edges++;
        tick(3);
        chk("speed_b", 3'(hall_edges % 2), speed_line);
        hall_in[0] = 1'b0;
        tick(5);
        chk("speed_hold", 3'(hall_edges % 2), speed_line);
        hall_in[0] = 1'b1;
        tick(500);
        chk("speed_glitch", 3'(hall_edges % 2), speed_line);
        chk("drive_off", 0, drive_strong);
        // Self-recovering faults: supply low, pump low and over-temperature.
        for (int i = 0; i < 3; i++) begin
            cmp.supply_low = (i == 0);
            cmp.pump_low = (i == 1);
            cmp.hot = (i == 2);
            tick(3);
            chk("fault_auto", 0, fault_line);
            chk("hiz_auto", 1, drivers_hiz);
            if (i != 1) chk("pump_off", 0, pump_on);
            if (i == 0) chk("pulldown_low", 1, gate_pulldown);
            cmp = '0;
            tick(3);
            chk("fault_clear", 1, fault_line);
            chk("hiz_clear", 0, drivers_hiz);
        end
        // Sense overcurrent must outlast its deglitch, then retries on its own.
        cmp.sense_ocp = 1'b1;
        tick(70);
        chk("sen_deglitch", 1, fault_line);
        tick(15);
        chk("sen_fault", 0, fault_line);
        cmp.sense_ocp = 1'b0;
        tick(RETRY + 10);
        chk("sen_retry", 1, fault_line);
        u_ctrl.pwm_edge();
        cmp.ds_trip = 1'b1;
        tick(85);
        chk("ds_deglitch", 1, fault_line);
        tick(10);
        chk("ds_fault", 0, fault_line);
        chk("ds_hiz", 1, drivers_hiz);
        cmp.ds_trip = 1'b0;
        tick(RETRY + 10);
        chk("ds_retry", 1, fault_line);
        // Latched gate fault stays until a valid enable pulse.
        cmp.gate_stuck = 1'b1;
        u_ctrl.pwm_edge();
        tick(90);
        chk("gdf_fault", 0, fault_line);
        cmp.gate_stuck = 1'b0;
        tick(RETRY + 20);
        chk("gdf_latched", 1, drivers_hiz);
        u_ctrl.reset_pulse();
        tick(5);
        chk("gdf_cleared", 1, fault_line);
        chk("regs_kept", 1, regulators_on);
        chk("sel_kept", exp_strap.gate_current, gcs);
        // Long enable low goes to sleep; the next wake latches the new straps.
        u_ctrl.drive_enable(1'b0);
        tick(1000);
        chk("regs_off", 0, regulators_on);
        chk("pulldown_on", 1, gate_pulldown);
        chk("fault_slept", 1, fault_line);
        strap_in.ds_threshold = 3'h6;
        exp_strap = strap_in;
        u_ctrl.drive_enable(1'b1);
        tick(WAKE + 5);
        chk("ds_sel_new", exp_strap.ds_threshold, dss);
        chk("gate_sel_new", exp_strap.gate_current, gcs);
        // With the off code latched, a long drain-source trip must not raise a fault.
        cmp.ds_trip = 1'b1;
        tick(100);
        chk("ds_off_fault", 1, fault_line);
        chk("ds_off_hiz", 0, drivers_hiz);
        cmp.ds_trip = 1'b0;
        // Clock enable low freezes the Hall filter; the edge lands once it returns.
        clk_en = 1'b0;
        hall_in[2] = 1'b1;
        tick(5);
        chk("speed_frozen", 3'(hall_edges % 2), speed_line);
        clk_en = 1'b1;
        hall_edges++;
        tick(3);
        chk("speed_c", 3'(hall_edges % 2), speed_line);
        stop_test();
    end
endmodule
`default_nettype wire
